/* core/flash_read_config_decode.sv */
// How it works
// - mode bit 0 gives synchronous burst reads, 1 asynchronous page reads, reset is 1.
// - latency codes 0 to 2 are reserved; 3 to 10 are usable.
// - polarity bit 0 makes wait active low, 1 makes it active high.
// - timing bit 0 releases wait with data, 1 one data cycle before.
// - clock-edge bit 0 uses falling edge, 1 rising edge, reset is rising.
// - wrap bit 0 wraps addresses inside burst length; 1, the default, never wraps.
// - length code 001 is 4, 010 is 8, 011 is 16, 111 continuous.
// - latency code counts valid edges from strobe release to first data word.
// - in synchronous mode with timing bit 0 wait stays asserted until valid data is on the bus.
`timescale 1ns/10ps
module flash_read_config_decode #(
	parameter int AW = 16,
	parameter int DW = 16,
	parameter int FIFO_DEPTH = 16
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	// flash bus pins from the host
	input wire logic flash_clk_i,
	input wire logic chip_enable_n_i,
	input wire logic output_enable_n_i,
	input wire logic address_valid_strobe_n_i,
	input wire logic [AW-1:0] flash_addr_i,
	// flash bus pins to the host
	output logic [DW-1:0] dq_o,
	output logic dq_oe_n_o,
	output logic wait_o,
	output logic wait_oe_n_o,
	output logic [AW-1:0] burst_addr_o,
	// array word stream
	input wire logic [DW-1:0] mem_data_i,
	input wire logic mem_valid_i,
	output logic mem_ready_o
);
	localparam int SW = AW + 4;

	////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [SW-1:0] sync1_r;
	logic [SW-1:0] sync2_r;
	logic clk_prev_r;
	logic pin_clk;
	logic pin_ce;
	logic pin_oe;
	logic pin_adv;
	logic [AW-1:0] pin_addr;
	logic rise;
	logic fall;
	logic valid_edge;
	logic bus_on;

	// two flops per pin, only the second stage is read
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync1_r <= {4'hf, {AW{1'b0}}};
			sync2_r <= {4'hf, {AW{1'b0}}};
		end else begin
			sync1_r <= {flash_clk_i, chip_enable_n_i, output_enable_n_i,
				address_valid_strobe_n_i, flash_addr_i};
			sync2_r <= sync1_r;
		end
	end

	assign pin_clk = sync2_r[SW-1];
	assign pin_ce = !sync2_r[SW-2];
	assign pin_oe = !sync2_r[SW-3];
	assign pin_adv = !sync2_r[SW-4];
	assign pin_addr = sync2_r[AW-1:0];
	assign bus_on = pin_ce && pin_oe;

	// link clock edge finder
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			clk_prev_r <= 1'b0;
		end else begin
			clk_prev_r <= pin_clk;
		end
	end

	assign rise = pin_clk && !clk_prev_r;
	assign fall = !pin_clk && clk_prev_r;

	////////////////////////////////////////////////////////////////
	// configuration register and its snapshot
	logic [15:0] cfg_r;
	logic [15:0] act_cfg_r;
	logic act_rm;
	logic [3:0] act_lc;
	logic act_wp;
	logic act_wd;
	logic act_ce;
	logic act_bw;
	logic [2:0] act_bl;
	logic [3:0] lc_eff;
	logic lc_bad;
	logic bl_bad;
	logic start;

	// software write; reserved bits cannot be set
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cfg_r <= flash_rcfg_pkg::CFG_RESET;
		end else if (reg_wr_i && reg_addr_i == flash_rcfg_pkg::CFG_OFS) begin
			cfg_r <= reg_wdata_i & flash_rcfg_pkg::CFG_WMASK;
		end
	end

	// a mid-burst write must not disturb the burst in flight
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			act_cfg_r <= flash_rcfg_pkg::CFG_RESET;
		end else if (start) begin
			act_cfg_r <= cfg_r;
		end
	end

	assign act_rm = act_cfg_r[flash_rcfg_pkg::RM_POS];
	assign act_lc = act_cfg_r[flash_rcfg_pkg::LC_LSB +: 4];
	assign act_wp = act_cfg_r[flash_rcfg_pkg::WP_POS];
	assign act_wd = act_cfg_r[flash_rcfg_pkg::WD_POS];
	assign act_ce = act_cfg_r[flash_rcfg_pkg::CE_POS];
	assign act_bw = act_cfg_r[flash_rcfg_pkg::BW_POS];
	assign act_bl = act_cfg_r[flash_rcfg_pkg::BL_LSB +: 3];

	// reserved latency codes run as the nearest usable one and are flagged
	always_comb begin
		lc_bad = 1'b0;
		lc_eff = act_lc;
		if (act_lc < flash_rcfg_pkg::LC_MIN) begin
			lc_bad = 1'b1;
			lc_eff = flash_rcfg_pkg::LC_MIN;
		end else if (act_lc > flash_rcfg_pkg::LC_MAX) begin
			lc_bad = 1'b1;
			lc_eff = flash_rcfg_pkg::LC_MAX;
		end
	end

	// only the chosen edge of the link clock advances the burst
	assign valid_edge = act_ce ? rise : fall;

	////////////////////////////////////////////////////////////////
	// burst length and wrap decode
	logic [4:0] blen;
	logic cont;
	logic [AW-1:0] wmask;

	// undefined length codes fall back to continuous, host must avoid them
	always_comb begin
		bl_bad = 1'b0;
		blen = 5'h00;
		cont = 1'b0;
		unique case (act_bl)
			flash_rcfg_pkg::BL_4: blen = 5'h04;
			flash_rcfg_pkg::BL_8: blen = 5'h08;
			flash_rcfg_pkg::BL_16: blen = 5'h10;
			flash_rcfg_pkg::BL_CONT: cont = 1'b1;
			default: begin
				cont = 1'b1;
				bl_bad = 1'b1;
			end
		endcase
	end

	assign wmask = AW'(blen) - 1'b1;

	////////////////////////////////////////////////////////////////
	// burst sequencer
	flash_rcfg_pkg::burst_st_t st_r;
	logic [3:0] lat_cnt_r;
	logic [AW-1:0] start_addr_r;
	logic [AW-1:0] offs_r;
	logic [4:0] words_r;
	logic dvalid_r;
	logic [DW-1:0] dq_r;
	logic [DW-1:0] fifo_data;
	logic fifo_valid;
	logic fifo_pop;
	logic [$clog2(FIFO_DEPTH):0] fifo_level;
	logic sync_mode;
	logic last_word;
	logic first_due;
	logic early;
	logic [AW-1:0] lin_addr;

	assign sync_mode = !act_rm;
	assign start = pin_adv && pin_ce;
	assign last_word = !cont && words_r == blen;
	assign first_due = st_r == flash_rcfg_pkg::ST_LAT && lat_cnt_r == lc_eff - 4'h1;
	assign fifo_pop = valid_edge && sync_mode && fifo_valid
		&& (first_due || (st_r == flash_rcfg_pkg::ST_DATA && !last_word));
	// next valid edge will present a word
	assign early = fifo_valid && (first_due || (st_r == flash_rcfg_pkg::ST_DATA && !last_word));

	// state; chip deselect ends the burst at once
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_r <= flash_rcfg_pkg::ST_IDLE;
		end else if (!pin_ce) begin
			st_r <= flash_rcfg_pkg::ST_IDLE;
		end else if (start) begin
			st_r <= flash_rcfg_pkg::ST_LAT;
		end else if (valid_edge && sync_mode) begin
			unique case (st_r)
				flash_rcfg_pkg::ST_IDLE: st_r <= flash_rcfg_pkg::ST_IDLE;
				flash_rcfg_pkg::ST_LAT: begin
					if (fifo_pop) begin
						st_r <= flash_rcfg_pkg::ST_DATA;
					end
				end
				flash_rcfg_pkg::ST_DATA: begin
					if (last_word) begin
						st_r <= flash_rcfg_pkg::ST_DONE;
					end
				end
				flash_rcfg_pkg::ST_DONE: st_r <= flash_rcfg_pkg::ST_DONE;
			endcase
		end
	end

	// latency counter holds at the last count while the array is late
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			lat_cnt_r <= 4'h0;
		end else if (start) begin
			lat_cnt_r <= 4'h0;
		end else if (valid_edge && st_r == flash_rcfg_pkg::ST_LAT && !first_due) begin
			lat_cnt_r <= lat_cnt_r + 4'h1;
		end
	end

	// address and word count of the burst
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			start_addr_r <= '0;
			offs_r <= '0;
			words_r <= 5'h00;
		end else if (start) begin
			start_addr_r <= pin_addr;
			offs_r <= '0;
			words_r <= 5'h00;
		end else if (fifo_pop) begin
			if (st_r == flash_rcfg_pkg::ST_DATA) begin
				offs_r <= offs_r + 1'b1;
			end
			if (!cont) begin
				words_r <= words_r + 5'h01;
			end
		end
	end

	// burst data word and valid flag change only on valid edges, the valid flag also clears on start or deselect; page reads track the fifo head
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dq_r <= '0;
			dvalid_r <= 1'b0;
		end else if (!pin_ce || start) begin
			dvalid_r <= 1'b0;
		end else if (!sync_mode) begin
			dq_r <= fifo_data;
			dvalid_r <= fifo_valid;
		end else if (valid_edge) begin
			dvalid_r <= fifo_pop;
			if (fifo_pop) begin
				dq_r <= fifo_data;
			end
		end
	end

	// wrapped address stays inside the aligned burst window
	assign lin_addr = start_addr_r + offs_r;
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			burst_addr_o <= '0;
		end else if (!act_bw && !cont) begin
			burst_addr_o <= (start_addr_r & ~wmask) | (lin_addr & wmask);
		end else begin
			burst_addr_o <= lin_addr;
		end
	end

	////////////////////////////////////////////////////////////////
	// wait and data pins
	logic wait_act;
	logic wait_act_r;

	// async reads keep wait deasserted; early release trades one cycle of margin
	always_comb begin
		wait_act = 1'b0;
		if (sync_mode && st_r != flash_rcfg_pkg::ST_IDLE) begin
			if (act_wd) begin
				wait_act = !(dvalid_r || early);
			end else begin
				wait_act = !dvalid_r;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wait_act_r <= 1'b0;
			wait_o <= 1'b0;
		end else begin
			wait_act_r <= wait_act;
			wait_o <= act_wp ? wait_act : !wait_act;
		end
	end

	assign wait_oe_n_o = !bus_on;
	assign dq_oe_n_o = !bus_on;
	assign dq_o = dq_r;

	////////////////////////////////////////////////////////////////
	// word buffer between array stream and flash bus
	word_fifo #(
		.WIDTH(DW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.in_data_i(mem_data_i),
		.in_valid_i(mem_valid_i),
		.in_ready_o(mem_ready_o),
		.out_data_o(fifo_data),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_pop),
		.level_o(fifo_level)
	);

	////////////////////////////////////////////////////////////////
	// register read, data one cycle after the strobe
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				flash_rcfg_pkg::CFG_OFS: reg_rdata_o <= cfg_r;
				flash_rcfg_pkg::STAT_OFS: reg_rdata_o <= {7'h00, 5'(fifo_level),
					bl_bad, lc_bad, st_r != flash_rcfg_pkg::ST_IDLE, dvalid_r};
				default: reg_rdata_o <= 16'h0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	sequence first_word_s;
		first_due && valid_edge && fifo_valid && sync_mode && pin_ce && !start;
	endsequence

	sequence burst_running_s;
		st_r != flash_rcfg_pkg::ST_IDLE && !start;
	endsequence

	async_wait_off_a: assert property (!sync_mode |=> !wait_act_r)
		else $error("wait asserted during asynchronous read");
	lat_code_range_a: assert property (lc_eff >= 4'h3 && lc_eff <= 4'ha)
		else $error("latency outside usable codes");
	wait_level_a: assert property (wait_act_r |-> wait_o == act_wp || $past(start))
		else $error("wait asserted at wrong level");
	wait_early_a: assert property (first_word_s and (act_wd == 1'b1)
		|=> !wait_act_r && dvalid_r)
		else $error("wait not released a cycle early");
	edge_pick_a: assert property (valid_edge |-> pin_clk == act_ce)
		else $error("burst advanced on the wrong clock edge");
	wrap_window_a: assert property (st_r == flash_rcfg_pkg::ST_DATA && !act_bw && !cont
		&& $stable(start_addr_r) |=> (burst_addr_o & ~wmask) == (start_addr_r & ~wmask))
		else $error("wrapped address left burst window");
	burst_len_a: assert property (!cont |-> words_r <= blen)
		else $error("burst ran past its length");
	first_data_a: assert property (first_word_s |=> dvalid_r && lat_cnt_r == lc_eff - 4'h1)
		else $error("first word not at latency count");
	wait_hold_a: assert property (burst_running_s and (act_wd == 1'b0) and sync_mode
		and !dvalid_r |=> wait_act_r)
		else $error("wait released without valid data");
	cfg_hold_a: assert property (!start |=> $stable(act_cfg_r))
		else $error("active configuration changed mid burst");
endmodule

/* core/flash_rcfg_pkg.sv */
package flash_rcfg_pkg;
	// register offsets on the plain register port
	localparam logic [3:0] CFG_OFS = 4'h0;
	localparam logic [3:0] STAT_OFS = 4'h4;
	// read configuration field positions
	localparam int RM_POS = 15;
	localparam int LC_LSB = 11;
	localparam int WP_POS = 10;
	localparam int WD_POS = 8;
	localparam int CE_POS = 6;
	localparam int BW_POS = 3;
	localparam int BL_LSB = 0;
	// reset value and writable bits; reserved and sequence bits stay 0
	localparam logic [15:0] CFG_RESET = 16'h994f;
	localparam logic [15:0] CFG_WMASK = 16'hfd4f;
	// usable latency codes
	localparam logic [3:0] LC_MIN = 4'h3;
	localparam logic [3:0] LC_MAX = 4'ha;
	// burst length codes
	localparam logic [2:0] BL_4 = 3'h1;
	localparam logic [2:0] BL_8 = 3'h2;
	localparam logic [2:0] BL_16 = 3'h3;
	localparam logic [2:0] BL_CONT = 3'h7;
	// burst sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_LAT, ST_DATA, ST_DONE} burst_st_t;
endpackage

/* core/word_fifo.sv */
`timescale 1ns/10ps
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// filling side
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	// draining side
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i,
	// fill level
	output logic [$clog2(DEPTH):0] level_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	logic push;
	logic pop;

	////////////////////////////////////////////////////////////////
	// full when pointers differ only in the wrap bit
	assign in_ready_o = (wr_ptr_r[AW] == rd_ptr_r[AW]) || (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]);
	assign out_valid_o = wr_ptr_r != rd_ptr_r;
	assign out_data_o = mem_r[rd_ptr_r[AW-1:0]];
	assign level_o = wr_ptr_r - rd_ptr_r;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	// storage, no reset needed on data
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
		end
	end

	// pointers
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end
endmodule

/* bench/host_ctrl_model.sv */
`timescale 1ns/10ps
module host_ctrl_model (
	// timing reference and wait pin
	input wire logic sys_clk_i,
	input wire logic wait_i,
	// flash bus pins
	output logic flash_clk_o,
	output logic ce_n_o,
	output logic oe_n_o,
	output logic adv_n_o,
	output logic [15:0] addr_o
);
	// idle bus, link clock parked low outside frames
	initial begin
		flash_clk_o = 1'b0;
		ce_n_o = 1'b1;
		oe_n_o = 1'b1;
		adv_n_o = 1'b1;
		addr_o = 16'h5a5a;
	end
	// strobe first, then link clock; counts selected edges issued before wait is first seen deasserted
	task frame(input logic [15:0] a, input int n, input logic fall, input logic pol,
		output int lat);
		logic gone;
		lat = 0;
		gone = 1'b0;
		@(posedge sys_clk_i);
		ce_n_o <= 1'b0;
		oe_n_o <= 1'b0;
		adv_n_o <= 1'b0;
		addr_o <= a;
		repeat (3) @(posedge sys_clk_i);
		adv_n_o <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		addr_o <= ~a; // address released: no stale value
		#13;
		// odd offset keeps link edges away from the system clock edges
		repeat (n) begin
			if (!fall && !gone && wait_i === pol) lat++;
			else if (!fall) gone = 1'b1;
			#160 flash_clk_o = 1'b1;
			if (fall && !gone && wait_i === pol) lat++;
			else if (fall) gone = 1'b1;
			#160 flash_clk_o = 1'b0;
		end
	endtask
	// end of frame
	task idle();
		@(posedge sys_clk_i);
		ce_n_o <= 1'b1;
		oe_n_o <= 1'b1;
		adv_n_o <= 1'b1;
	endtask
endmodule

/* bench/flash_read_config_decode_tb.sv */
`timescale 1ns/10ps
module flash_read_config_decode_tb;
	logic sys_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [3:0] reg_addr_i = 4'h0;
	logic [15:0] reg_wdata_i = 16'h0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [15:0] mem_data_i = 16'h0;
	logic mem_valid_i = 1'b0;
	logic [15:0] reg_rdata_o, dq_o, burst_addr_o, flash_addr_i;
	logic flash_clk_i, ce_n, oe_n, adv_n, dq_oe_n_o, wait_o, wait_oe_n_o, mem_ready_o;
	int error_cnt = 0;
	int compares = 0;
	int cyc = 0;
	int lat;
	logic [15:0] q[$];
	logic [15:0] s, c;
	logic [3:0] lc;
	logic wd, wp, ce;
	logic [2:0] bl_tab [3] = '{3'h1, 3'h2, 3'h3};

	flash_read_config_decode dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .flash_clk_i(flash_clk_i),
		.chip_enable_n_i(ce_n), .output_enable_n_i(oe_n),
		.address_valid_strobe_n_i(adv_n), .flash_addr_i(flash_addr_i), .dq_o(dq_o),
		.dq_oe_n_o(dq_oe_n_o), .wait_o(wait_o), .wait_oe_n_o(wait_oe_n_o),
		.burst_addr_o(burst_addr_o), .mem_data_i(mem_data_i), .mem_valid_i(mem_valid_i),
		.mem_ready_o(mem_ready_o));
	host_ctrl_model host (.sys_clk_i(sys_clk_i), .wait_i(wait_o), .flash_clk_o(flash_clk_i),
		.ce_n_o(ce_n), .oe_n_o(oe_n), .adv_n_o(adv_n), .addr_o(flash_addr_i));

	////////////////////////////////////////////////////////////////////////////////
	// clock and hang guard; bursts need a few hundred cycles each
	initial forever #20 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// helpers
	task stop_test();
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	// read data appear in the cycle after the strobe and hold until the next read
	task rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask
	function logic [15:0] cfg(input logic rm, input logic [3:0] l, input logic p, input logic
		d, input logic e, input logic w, input logic [2:0] b);
		cfg = {rm, l, p, 1'b0, d, 1'b0, e, 2'b00, w, b};
	endfunction
	// top the fifo up until it refuses
	task fill();
		logic [15:0] d;
		rd(flash_rcfg_pkg::STAT_OFS, s);
		repeat (16 - s[8:4]) begin
			@(posedge sys_clk_i);
			d = $urandom;
			mem_data_i <= d;
			mem_valid_i <= 1'b1;
			q.push_back(d);
		end
		@(posedge sys_clk_i);
		mem_valid_i <= 1'b0;
		#1 chk("fifo ready", 16'h0, mem_ready_o);
	endtask
	task burst(input logic [15:0] a, input int n, input logic [15:0] k);
		wr(flash_rcfg_pkg::CFG_OFS, k);
		host.frame(a, n, !k[6], k[10], lat);
		repeat (4) @(posedge sys_clk_i);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		void'($urandom(32'h852d45c8));
		repeat (12) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		rd(flash_rcfg_pkg::CFG_OFS, s);
		chk("cfg reset", flash_rcfg_pkg::CFG_RESET, s);
		rd(4'hc, s);
		chk("unmapped", 16'h0, s);
		$display("test reset done");
		repeat (4) begin
			c = $urandom;
			wr(flash_rcfg_pkg::CFG_OFS, c);
			rd(flash_rcfg_pkg::CFG_OFS, s);
			chk("cfg rw", c & flash_rcfg_pkg::CFG_WMASK, s);
		end
		$display("test regs done");
		// page mode: wait parked deasserted, head word shown, nothing consumed
		fill();
		wp = $urandom;
		burst(16'h0, 2, cfg(1'b1, 4'h3, wp, 1'b1, 1'b1, 1'b1, 3'h7));
		chk("async wait", !wp, wait_o);
		chk("async data", q[0], dq_o);
		rd(flash_rcfg_pkg::STAT_OFS, s);
		chk("async level", 16'h10, s[8:4]);
		host.idle();
		$display("test async done");
		// fixed lengths with random latency, polarity, release timing and edge
		for (int i = 0; i < 3; i++) begin
			lc = 4'h3 + 4'($urandom_range(7));
			wd = $urandom;
			wp = $urandom;
			ce = $urandom;
			fill();
			burst($urandom, lc + 24, cfg(1'b0, lc, wp, wd, ce, 1'b1, bl_tab[i]));
			chk("latency", lc - wd, lat);
			chk("wait end", wp, wait_o);
			rd(flash_rcfg_pkg::STAT_OFS, s);
			chk("level", 16 - (4 << i), s[8:4]);
			host.idle();
		end
		$display("test lengths done");
		for (int w = 0; w < 2; w++) begin
			fill();
			burst(16'h0012, 30, cfg(1'b0, 4'h3, 1'b0, 1'b0, 1'b1, w[0], 3'h1));
			chk("wrap addr", w ? 16'h0015 : 16'h0011, burst_addr_o);
			host.idle();
		end
		$display("test wrap done");
		// continuous burst drains the fifo, then stalls with wait asserted
		fill();
		burst($urandom, 40, cfg(1'b0, 4'h3, wp, 1'b0, 1'b1, 1'b1, 3'h7));
		rd(flash_rcfg_pkg::STAT_OFS, s);
		chk("cont level", 16'h0, s[8:4]);
		chk("stall wait", wp, wait_o);
		host.idle();
		$display("test continuous done");
		// reserved codes on purpose: latency runs as 3, both flags raised
		fill();
		burst($urandom, 30, cfg(1'b0, 4'h1, 1'b1, 1'b0, 1'b1, 1'b1, 3'h5));
		chk("rsvd latency", 16'h3, lat);
		rd(flash_rcfg_pkg::STAT_OFS, s);
		chk("rsvd flags", 16'h3, s[3:2]);
		host.idle();
		$display("test reserved done");
		stop_test();
	end
endmodule
